//--- core/julc_top.sv
// upper-lane link configuration registers with axi4-lite slave and link-side sampling
// What this block does
// - force bit loads multiframe counter from preset
// - preset field gives counter starting value
// - override, checksum and id registers writable only with write-select set
// - lane 5 id: default 00101 or programmed
// - lane 6 id: default 00110 or programmed
// - lane 7 id: default 00111 or programmed
// - lane 8 id: default 01000 or programmed
// - lane 5 checksum: computed or upper byte
// - lanes 6-8 checksum: computed or programmed byte
// - lane 5/6 checksum register byte layout
// - lane 7/8 checksum register byte layout
// - lane 5/6 identifier register field layout
// - all fields reset zero, read/write
// - lane 7/8 identifier register field layout
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "julc_regs.svh"

module julc_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // axi4-lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link control
  input  wire logic        link_init,
  input  wire logic        mfc_restart,
  // checksums computed by the link framer
  input  wire logic [7:0]  lane5_fchk_calc,
  input  wire logic [7:0]  lane6_fchk_calc,
  input  wire logic [7:0]  lane7_fchk_calc,
  input  wire logic [7:0]  lane8_fchk_calc,
  // sampled lane identifiers
  output logic [4:0]       lane5_tx_id,
  output logic [4:0]       lane6_tx_id,
  output logic [4:0]       lane7_tx_id,
  output logic [4:0]       lane8_tx_id,
  // sampled lane checksums
  output logic [7:0]       lane5_tx_fchk,
  output logic [7:0]       lane6_tx_fchk,
  output logic [7:0]       lane7_tx_fchk,
  output logic [7:0]       lane8_tx_fchk,
  // local multiframe counter
  output logic [4:0]       mfc_count,
  output logic             mfc_wrap
);

  // address decode shared by write and read paths
  function automatic julc_pkg::julc_sel_t dec_addr(input logic [31:0] a);
    if (a == `JULC_ADDR(`JULC_IDX_CFG3))
      dec_addr = julc_pkg::SEL_CFG3;
    else if (a == `JULC_ADDR(`JULC_IDX_MFC))
      dec_addr = julc_pkg::SEL_MFC;
    else if (a == `JULC_ADDR(`JULC_IDX_OVR))
      dec_addr = julc_pkg::SEL_OVR;
    else if (a == `JULC_ADDR(`JULC_IDX_CS56))
      dec_addr = julc_pkg::SEL_CS56;
    else if (a == `JULC_ADDR(`JULC_IDX_CS78))
      dec_addr = julc_pkg::SEL_CS78;
    else if (a == `JULC_ADDR(`JULC_IDX_ID56))
      dec_addr = julc_pkg::SEL_ID56;
    else if (a == `JULC_ADDR(`JULC_IDX_ID78))
      dec_addr = julc_pkg::SEL_ID78;
    else
      dec_addr = julc_pkg::SEL_NONE;
  endfunction

  // writable bits per register; unused bits are dropped so they read zero
  function automatic logic [15:0] reg_mask(input julc_pkg::julc_sel_t s);
    case (s)
      julc_pkg::SEL_CFG3: reg_mask = `JULC_MASK_CFG3;
      julc_pkg::SEL_MFC:  reg_mask = `JULC_MASK_MFC;
      julc_pkg::SEL_OVR:  reg_mask = `JULC_MASK_OVR;
      julc_pkg::SEL_CS56: reg_mask = `JULC_MASK_CS;
      julc_pkg::SEL_CS78: reg_mask = `JULC_MASK_CS;
      julc_pkg::SEL_ID56: reg_mask = `JULC_MASK_ID;
      julc_pkg::SEL_ID78: reg_mask = `JULC_MASK_ID;
      default:            reg_mask = `JULC_REG_RESET;
    endcase
  endfunction

  // register storage, indexed by select code
  logic [15:0] regs_q [7];
  logic [15:0] regs_d [7];
  // write channel state
  logic        aw_full_q, aw_full_d;
  logic        w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d;
  logic [15:0] wdata_q, wdata_d;
  logic [1:0]  wstrb_q, wstrb_d;
  logic        awready_q, awready_d;
  logic        wready_q, wready_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  // write commit helpers
  julc_pkg::julc_sel_t wsel;
  logic [15:0] wmask;
  logic        wr_sel_on;

  // override, checksum and id registers may only be written while write-select is set
  assign wr_sel_on = regs_q[julc_pkg::SEL_CFG3][`JULC_CFG3_WR_SEL_BIT];

  // write path: take address and data in either order, commit once both are held
  always_comb
  begin
    regs_d    = regs_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    wsel      = julc_pkg::SEL_NONE;
    wmask     = `JULC_REG_RESET;
    if (awready_q && s_axi_awvalid)
    begin
      aw_full_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (wready_q && s_axi_wvalid)
    begin
      w_full_d = 1'b1;
      wdata_d  = s_axi_wdata[15:0];
      wstrb_d  = s_axi_wstrb[1:0];
    end
    // commit in the same edge that completes the pair
    if (aw_full_d && w_full_d && !bvalid_q)
    begin
      wsel = dec_addr(awaddr_d);
      // only the two low byte lanes carry register bits
      wmask = reg_mask(wsel) & {{8{wstrb_d[1]}}, {8{wstrb_d[0]}}};
      if (wsel == julc_pkg::SEL_NONE)
        bresp_d = `JULC_RESP_SLVERR;
      else
      begin
        bresp_d = `JULC_RESP_OKAY;
        // locked bank: write is dropped but still answered okay
        if (wsel <= julc_pkg::SEL_MFC || wr_sel_on)
          regs_d[wsel] = (regs_q[wsel] & ~wmask) | (wdata_d & wmask);
      end
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // accept again only once the response is gone
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
  end

  // write path registers; all fields come out of reset as zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 7; i++)
        regs_q[i] <= `JULC_REG_RESET;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 16'h0000;
      wstrb_q   <= 2'h0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `JULC_RESP_OKAY;
    end
    else
    begin
      regs_q    <= regs_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // read channel state
  julc_pkg::julc_rd_state_t rd_state_q, rd_state_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  julc_pkg::julc_sel_t rsel;

  // read path: one read at a time, data answered the cycle after the address
  always_comb
  begin
    rd_state_d = rd_state_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    rsel       = dec_addr(s_axi_araddr);
    case (rd_state_q)
      julc_pkg::RD_IDLE:
        if (s_axi_arvalid)
        begin
          rd_state_d = julc_pkg::RD_DATA;
          if (rsel == julc_pkg::SEL_NONE)
          begin
            rdata_d = 32'h0000_0000;
            rresp_d = `JULC_RESP_SLVERR;
          end
          else
          begin
            // bank reads are never locked; upper half always zero
            rdata_d = {16'h0000, regs_q[rsel]};
            rresp_d = `JULC_RESP_OKAY;
          end
        end
      julc_pkg::RD_DATA:
        if (s_axi_rready)
          rd_state_d = julc_pkg::RD_IDLE;
      default:
        rd_state_d = julc_pkg::RD_IDLE;
    endcase
  end

  // read path registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state_q <= julc_pkg::RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `JULC_RESP_OKAY;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
    end
  end

  // link-side sampled values, one entry per lane 5..8
  logic [4:0] id_q [4];
  logic [4:0] id_d [4];
  logic [7:0] fchk_q [4];
  logic [7:0] fchk_d [4];
  logic [4:0] mfc_q, mfc_d;
  logic       wrap_q, wrap_d;
  // candidate values per lane
  logic [4:0] id_def [4];
  logic [4:0] id_prog [4];
  logic [7:0] cs_prog [4];
  logic [7:0] cs_calc [4];
  logic [15:0] ovr_r, mfc_r;

  assign ovr_r = regs_q[julc_pkg::SEL_OVR];
  assign mfc_r = regs_q[julc_pkg::SEL_MFC];

  // lane candidates; field slices follow the register layouts
  always_comb
  begin
    id_def[0]  = `JULC_LANE5_DEF_ID;
    id_def[1]  = `JULC_LANE6_DEF_ID;
    id_def[2]  = `JULC_LANE7_DEF_ID;
    id_def[3]  = `JULC_LANE8_DEF_ID;
    id_prog[0] = regs_q[julc_pkg::SEL_ID56][`JULC_HI_ID_LSB +: 5];
    id_prog[1] = regs_q[julc_pkg::SEL_ID56][`JULC_LO_ID_LSB +: 5];
    id_prog[2] = regs_q[julc_pkg::SEL_ID78][`JULC_HI_ID_LSB +: 5];
    id_prog[3] = regs_q[julc_pkg::SEL_ID78][`JULC_LO_ID_LSB +: 5];
    cs_prog[0] = regs_q[julc_pkg::SEL_CS56][`JULC_HI_CS_LSB +: 8];
    cs_prog[1] = regs_q[julc_pkg::SEL_CS56][`JULC_LO_CS_LSB +: 8];
    cs_prog[2] = regs_q[julc_pkg::SEL_CS78][`JULC_HI_CS_LSB +: 8];
    cs_prog[3] = regs_q[julc_pkg::SEL_CS78][`JULC_LO_CS_LSB +: 8];
    cs_calc[0] = lane5_fchk_calc;
    cs_calc[1] = lane6_fchk_calc;
    cs_calc[2] = lane7_fchk_calc;
    cs_calc[3] = lane8_fchk_calc;
  end

  // link sampling and multiframe counter next state
  always_comb
  begin
    id_d   = id_q;
    fchk_d = fchk_q;
    // mid-link register writes must not disturb a running link
    if (link_init)
      for (int k = 0; k < 4; k++)
      begin
        id_d[k] = ovr_r[`JULC_OVR_ID_MSB - k] ? id_prog[k] : id_def[k];
        fchk_d[k] = ovr_r[`JULC_OVR_CS_MSB - k] ? cs_prog[k] : cs_calc[k];
      end
    wrap_d = 1'b0;
    if (mfc_restart)
    begin
      // forced start value, else the default zero start
      if (mfc_r[`JULC_MFC_FORCE_BIT])
        mfc_d = mfc_r[`JULC_MFC_PRESET_LSB +: 5];
      else
        mfc_d = `JULC_MFC_ZERO;
    end
    else if (mfc_q == `JULC_MFC_LAST)
    begin
      mfc_d  = `JULC_MFC_ZERO;
      wrap_d = 1'b1;
    end
    else
      mfc_d = mfc_q + 5'h01;
  end

  // link-side registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_q[0]   <= `JULC_LANE5_DEF_ID;
      id_q[1]   <= `JULC_LANE6_DEF_ID;
      id_q[2]   <= `JULC_LANE7_DEF_ID;
      id_q[3]   <= `JULC_LANE8_DEF_ID;
      for (int k = 0; k < 4; k++)
        fchk_q[k] <= 8'h00;
      mfc_q  <= `JULC_MFC_ZERO;
      wrap_q <= 1'b0;
    end
    else
    begin
      id_q   <= id_d;
      fchk_q <= fchk_d;
      mfc_q  <= mfc_d;
      wrap_q <= wrap_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = (rd_state_q == julc_pkg::RD_IDLE);
  assign s_axi_rvalid  = (rd_state_q == julc_pkg::RD_DATA);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign lane5_tx_id   = id_q[0];
  assign lane6_tx_id   = id_q[1];
  assign lane7_tx_id   = id_q[2];
  assign lane8_tx_id   = id_q[3];
  assign lane5_tx_fchk = fchk_q[0];
  assign lane6_tx_fchk = fchk_q[1];
  assign lane7_tx_fchk = fchk_q[2];
  assign lane8_tx_fchk = fchk_q[3];
  assign mfc_count     = mfc_q;
  assign mfc_wrap      = wrap_q;

endmodule

//--- core/julc_regs.svh
// register offsets, field positions, masks and reset values of the upper-lane config bank
`ifndef JULC_REGS_SVH
`define JULC_REGS_SVH
// register indexes; byte address is four times the index
`define JULC_IDX_CFG3 32'h0000_0003
`define JULC_IDX_MFC 32'h0000_0078
`define JULC_IDX_OVR 32'h0000_0086
`define JULC_IDX_CS56 32'h0000_0087
`define JULC_IDX_CS78 32'h0000_0088
`define JULC_IDX_ID56 32'h0000_0089
`define JULC_IDX_ID78 32'h0000_008A
`define JULC_ADDR(i) ((i) << 2)
// writable bits of each register; all other bits read as zero
`define JULC_MASK_CFG3 16'h0020
`define JULC_MASK_MFC 16'hFC00
`define JULC_MASK_OVR 16'hFF00
`define JULC_MASK_CS 16'hFFFF
`define JULC_MASK_ID 16'h1F1F
// field positions
`define JULC_CFG3_WR_SEL_BIT 5
`define JULC_MFC_FORCE_BIT 15
`define JULC_MFC_PRESET_LSB 10
`define JULC_OVR_ID_MSB 15
`define JULC_OVR_CS_MSB 11
`define JULC_HI_ID_LSB 8
`define JULC_LO_ID_LSB 0
`define JULC_HI_CS_LSB 8
`define JULC_LO_CS_LSB 0
// reset and default values
`define JULC_REG_RESET 16'h0000
`define JULC_LANE5_DEF_ID 5'h05
`define JULC_LANE6_DEF_ID 5'h06
`define JULC_LANE7_DEF_ID 5'h07
`define JULC_LANE8_DEF_ID 5'h08
`define JULC_MFC_LAST 5'h1F
`define JULC_MFC_ZERO 5'h00
// axi responses
`define JULC_RESP_OKAY 2'h0
`define JULC_RESP_SLVERR 2'h2
`endif

//--- core/julc_pkg.sv
// types shared by the upper-lane config bank
package julc_pkg;
  // register select, also the index into the register array
  typedef enum logic [2:0] {
    SEL_CFG3 = 3'b000,
    SEL_MFC  = 3'b001,
    SEL_OVR  = 3'b010,
    SEL_CS56 = 3'b011,
    SEL_CS78 = 3'b100,
    SEL_ID56 = 3'b101,
    SEL_ID78 = 3'b110,
    SEL_NONE = 3'b111
  } julc_sel_t;
  // read channel states
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } julc_rd_state_t;
endpackage

//--- testbench/julc_top_sva.sv
// port-level assertions for the upper-lane config bank
`timescale 1ns/1ps
module julc_top_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // link side
  input wire logic        link_init,
  input wire logic        mfc_restart,
  input wire logic [4:0]  lane5_tx_id,
  input wire logic [4:0]  lane8_tx_id,
  input wire logic [7:0]  lane5_tx_fchk,
  input wire logic [7:0]  lane8_tx_fchk,
  input wire logic [4:0]  mfc_count,
  input wire logic        mfc_wrap
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_b_ans;
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read not answered");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_arready;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("read upper half set");
  // rst_n in the antecedent keeps the edge that releases reset out of the check
  property p_mfc_inc;
    rst_n && !mfc_restart |=> mfc_count == $past(mfc_count) + 5'd1;
  endproperty
  a_mfc_inc: assert property (p_mfc_inc) else $error("counter did not step");
  property p_mfc_wrap;
    mfc_wrap |-> mfc_count == 5'd0 && $past(mfc_count) == 5'd31;
  endproperty
  a_mfc_wrap: assert property (p_mfc_wrap) else $error("bad wrap pulse");
  property p_tx_hold;
    !link_init |=> $stable(lane5_tx_id) && $stable(lane8_tx_id)
      && $stable(lane5_tx_fchk) && $stable(lane8_tx_fchk);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("lane output moved");
endmodule
bind julc_top julc_top_sva u_sva (
  .core_clk      (core_clk),
  .rst_n         (rst_n),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .link_init     (link_init),
  .mfc_restart   (mfc_restart),
  .lane5_tx_id   (lane5_tx_id),
  .lane8_tx_id   (lane8_tx_id),
  .lane5_tx_fchk (lane5_tx_fchk),
  .lane8_tx_fchk (lane8_tx_fchk),
  .mfc_count     (mfc_count),
  .mfc_wrap      (mfc_wrap)
);

//--- testbench/tb.sv
// self-checking bench for the upper-lane config bank
`timescale 1ns/1ps
`include "julc_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
  // clock, reset and bus
  logic        core_clk, rst_n;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  // link side
  logic        link_init, mfc_restart, mfc_wrap;
  logic [4:0]  id5, id6, id7, id8, mfc_count;
  logic [7:0]  fc5, fc6, fc7, fc8, cs5, cs6, cs7, cs8;
  // bookkeeping
  int          failures, n_compared;
  logic [15:0] rd;
  // byte addresses: cfg3, mfc, ovr, cs56, cs78, id56, id78
  logic [31:0] adr [7] = '{`JULC_ADDR(`JULC_IDX_CFG3), `JULC_ADDR(`JULC_IDX_MFC),
    `JULC_ADDR(`JULC_IDX_OVR), `JULC_ADDR(`JULC_IDX_CS56), `JULC_ADDR(`JULC_IDX_CS78),
    `JULC_ADDR(`JULC_IDX_ID56), `JULC_ADDR(`JULC_IDX_ID78)};
  // values written and read back; software keeps unused bits at zero
  logic [15:0] ev [5] = '{16'hFF00, 16'hA55A, 16'h3CC3, 16'h0914, 16'h0B0C};
  julc_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_init(link_init), .mfc_restart(mfc_restart), .lane5_fchk_calc(fc5),
    .lane6_fchk_calc(fc6), .lane7_fchk_calc(fc7), .lane8_fchk_calc(fc8),
    .lane5_tx_id(id5), .lane6_tx_id(id6), .lane7_tx_id(id7), .lane8_tx_id(id8),
    .lane5_tx_fchk(cs5), .lane6_tx_fchk(cs6), .lane7_tx_fchk(cs7), .lane8_tx_fchk(cs8),
    .mfc_count(mfc_count), .mfc_wrap(mfc_wrap)
  );
  // 25 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // single exit point of the run
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // write: bready rises a cycle late so the held answer gets exercised
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    int k;
    @(posedge core_clk);
    awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge core_clk);
      if (bvalid && bready) break;
      if (!awvalid && !wvalid) bready <= 1'b1;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    if (k == 40) begin failures++; give_verdict(); end
    resp = bresp; bready <= 1'b0;
  endtask
  // read: same late-ready habit on the data channel
  task automatic rd_reg(input logic [31:0] a);
    int k;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge core_clk);
      if (rvalid && rready) break;
      if (!arvalid) rready <= 1'b1;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    if (k == 40) begin failures++; give_verdict(); end
    rd = rdata[15:0]; resp = rresp; rready <= 1'b0;
  endtask
  // one-cycle pulse on link_init or mfc_restart, then look one cycle later
  task automatic pulse(input bit restart);
    @(posedge core_clk);
    if (restart) mfc_restart <= 1'b1;
    else link_init <= 1'b1;
    @(posedge core_clk);
    link_init <= 1'b0; mfc_restart <= 1'b0;
    #1;
  endtask
  task automatic chk_lanes(input logic [19:0] ids, input logic [31:0] cs);
    `CHK({id5, id6, id7, id8}, ids)
    `CHK({cs5, cs6, cs7, cs8}, cs)
  endtask
  initial
  begin
    failures = 0; n_compared = 0; rst_n = 1'b0; wstrb = 4'h3;
    awaddr = '0; wdata = '0; araddr = '0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; link_init = 0; mfc_restart = 0;
    fc5 = 8'h11; fc6 = 8'h22; fc7 = 8'h33; fc8 = 8'h44;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // everything comes up zero, lanes carry defaults and computed checksums
    foreach (adr[i]) begin rd_reg(adr[i]); `CHK(rd, 16'h0000) end
    pulse(0);
    chk_lanes({5'h05, 5'h06, 5'h07, 5'h08}, 32'h1122_3344);
    // override bank is locked while write-select is clear
    wr(adr[2], 16'hFF00);
    `CHK(resp, `JULC_RESP_OKAY)
    rd_reg(adr[2]);
    `CHK(rd, 16'h0000)
    wr(adr[0], 16'h0020);
    for (int i = 0; i < 5; i++)
    begin
      wr(adr[i + 2], ev[i]);
      rd_reg(adr[i + 2]);
      `CHK(rd, ev[i])
    end
    // nothing reaches the lanes until the next link init
    chk_lanes({5'h05, 5'h06, 5'h07, 5'h08}, 32'h1122_3344);
    pulse(0);
    chk_lanes({5'h09, 5'h14, 5'h0B, 5'h0C}, 32'hA55A_3CC3);
    // mixed enables: each bit seen both ways
    wr(adr[2], 16'hA500);
    pulse(0);
    chk_lanes({5'h09, 5'h06, 5'h0B, 5'h08}, 32'h115A_33C3);
    // forced counter start from the preset, then default start
    wr(adr[1], 16'hD400);
    rd_reg(adr[1]);
    `CHK(rd, 16'hD400)
    pulse(1);
    `CHK(mfc_count, 5'h15)
    wr(adr[1], 16'h5400);
    pulse(1);
    `CHK(mfc_count, 5'h00)
    // high byte lane only: lane 5 checksum cleared, lane 6 kept
    @(posedge core_clk);
    wstrb <= 4'h2;
    wr(adr[3], 16'h0000);
    rd_reg(adr[3]);
    `CHK(rd, 16'h005A)
    // unmapped place
    wr(32'h0000_0100, 16'h1234);
    `CHK(resp, `JULC_RESP_SLVERR)
    rd_reg(32'h0000_0100);
    `CHK({resp, rd}, {`JULC_RESP_SLVERR, 16'h0000})
    repeat (40) @(posedge core_clk);
    give_verdict();
  end
endmodule
